/* core/apc_top.sv */
// Converter power, reference and interrupt control with an AHB-Lite register slave
`timescale 1ns/1ns
module apc_top
  import apc_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  // Converter analog side
  input  wire logic                        conversion_done_evt,
  input  wire logic                        calibration_done_evt,
  input  wire logic [APC_LIMIT_EVENTS-1:0] limit_evt,
  input  wire logic [APC_RESULT_WIDTH-1:0] result_in,
  output logic                             converter_power_on,
  output logic                             input_buffer_power_on,
  output logic                             reference_buffer_power_on,
  output logic                             charge_pump_power_on,
  output logic                             converter_clock_enable,
  output logic                             rail_1v8_ref_select,
  output logic                             external_ref_select,
  output logic                             correction_bypass,
  output logic                             sequencer_run,
  output logic                             converter_usable,
  output logic                             converter_irq
);

  localparam int NSYNC = APC_LIMIT_EVENTS + 2;

  typedef struct packed {
    logic [7:0]                  glb;
    logic [7:0]                  pwr;
    logic [7:0]                  clkref;
    logic [7:0]                  inref;
    logic [7:0]                  byp;
    logic [7:0]                  ie;
    logic [7:0]                  st0;
    logic [7:0]                  st1;
    logic [7:0]                  st2;
    logic [7:0]                  st3;
    logic [7:0]                  rr;
    logic [APC_RESULT_WIDTH-1:0] result;
    logic                        pend;
    logic                        pend_wr;
    logic                        pend_ok;
    logic [10:0]                 pend_idx;
    logic                        hready;
    logic [31:0]                 hrdata;
    logic [NSYNC-1:0]            evt_s1;
    logic [NSYNC-1:0]            evt_s2;
    logic [NSYNC-1:0]            evt_prev;
    logic [APC_RESULT_WIDTH-1:0] res_s1;
    logic [APC_RESULT_WIDTH-1:0] res_s2;
    logic                        ready_prev;
    logic                        irq;
  } apc_state_t;

  apc_state_t   s_r;
  apc_state_t   s_nxt;
  apc_settle_if settle ();

  // ==========================================================================
  // Charge-pump settling timer
  // ==========================================================================
  apc_settle_timer u_settle (
    .clk (clk),
    .rst (rst),
    .st  (settle.tmr)
  );

  assign settle.pump_on  = s_r.pwr[APC_CHARGE_PUMP_POWER_ON_BIT];
  assign settle.clock_on = s_r.clkref[APC_CLOCK_ENABLE_BIT];

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  logic [NSYNC-1:0]            evt_rise;
  logic                        accept;
  logic                        rd;
  logic                        wr;
  logic                        ready_now;
  logic [7:0]                  wbyte;
  logic [7:0]                  rbyte;
  logic [7:0]                  set0;
  logic [7:0]                  clr0;
  logic [7:0]                  clr1;
  logic [7:0]                  clr2;
  logic [7:0]                  clr3;
  logic [APC_LIMIT_EVENTS-1:0] lim_rise;

  always_comb begin
    s_nxt    = s_r;
    evt_rise = s_r.evt_s2 & ~s_r.evt_prev;
    lim_rise = evt_rise[APC_LIMIT_EVENTS-1:0];
    accept   = hsel && hready && htrans[1];
    rd       = s_r.pend && !s_r.pend_wr && s_r.pend_ok;
    wr       = s_r.pend && s_r.pend_wr && s_r.pend_ok;
    wbyte    = hwdata[7:0];
    rbyte    = 8'h00;
    clr0     = 8'h00;
    clr1     = 8'h00;
    clr2     = 8'h00;
    clr3     = 8'h00;

    // Pin-side inputs pass two flops before any use
    s_nxt.evt_s1   = {calibration_done_evt, conversion_done_evt, limit_evt};
    s_nxt.evt_s2   = s_r.evt_s1;
    s_nxt.evt_prev = s_r.evt_s2;
    s_nxt.res_s1   = result_in;
    s_nxt.res_s2   = s_r.res_s1;

    // Ready once every needed circuit is powered, the converter clock runs and the pump has settled
    ready_now = s_r.pwr[APC_CONVERTER_POWER_ON_BIT]
              & s_r.pwr[APC_INPUT_BUFFER_POWER_ON_BIT]
              & (s_r.pwr[APC_REFERENCE_BUFFER_POWER_ON_BIT]
                 | s_r.inref[APC_EXTERNAL_REF_SELECT_BIT])
              & s_r.clkref[APC_CLOCK_ENABLE_BIT]
              & settle.settled;
    s_nxt.ready_prev = ready_now;

    // Converter result captured at conversion done
    if (evt_rise[APC_LIMIT_EVENTS]) begin
      s_nxt.result = s_r.res_s2;
    end

    // Read data mux
    unique case (s_r.pend_idx)
      APC_IDX_GLOBAL_IRQ_OUTPUT_ENABLES:  rbyte = s_r.glb;
      APC_IDX_CONVERTER_POWER_CONTROLS:   rbyte = s_r.pwr;
      APC_IDX_CONVERTER_CLOCK_REF_SELECT: rbyte = s_r.clkref;
      APC_IDX_CONVERTER_INPUT_REF_CTRL:   rbyte = s_r.inref;
      APC_IDX_RESULT_LOW:                 rbyte = s_r.result[7:0];
      APC_IDX_CORRECTION_BYPASS_CONTROL:
        rbyte = {s_r.byp[7], 5'h00, s_r.result[9:8]};
      APC_IDX_CONVERTER_IRQ_ENABLES:      rbyte = s_r.ie;
      APC_IDX_CONVERTER_IRQ_STATUS_0:     rbyte = s_r.st0;
      APC_IDX_CONVERTER_IRQ_STATUS_1:     rbyte = s_r.st1;
      APC_IDX_CONVERTER_IRQ_STATUS_2:     rbyte = s_r.st2;
      APC_IDX_CONVERTER_IRQ_STATUS_3:     rbyte = s_r.st3;
      APC_IDX_ROUND_ROBIN_RUN_CONTROL:    rbyte = s_r.rr;
      default:                            rbyte = 8'h00;
    endcase

    // Clear-on-read of the status registers
    if (rd) begin
      unique case (s_r.pend_idx)
        APC_IDX_CONVERTER_IRQ_STATUS_0: clr0 = 8'hff;
        APC_IDX_CONVERTER_IRQ_STATUS_1: clr1 = 8'hff;
        APC_IDX_CONVERTER_IRQ_STATUS_2: clr2 = 8'hff;
        APC_IDX_CONVERTER_IRQ_STATUS_3: clr3 = 8'hff;
        default: ;
      endcase
    end

    // Event flags; a set in the clearing cycle survives
    set0                      = 8'h00;
    set0[APC_DONE_BIT]        = evt_rise[APC_LIMIT_EVENTS];
    set0[APC_CALIBRATION_BIT] = evt_rise[APC_LIMIT_EVENTS+1];
    set0[APC_READY_BIT]       = ready_now && !s_r.ready_prev;
    s_nxt.st0 = (s_r.st0 & ~clr0) | set0;
    s_nxt.st1 = (s_r.st1 & ~clr1) | lim_rise[7:0];
    s_nxt.st2 = (s_r.st2 & ~clr2) | lim_rise[15:8];
    s_nxt.st3 = (s_r.st3 & ~clr3) | lim_rise[23:16];

    // Register writes
    if (wr) begin
      unique case (s_r.pend_idx)
        APC_IDX_GLOBAL_IRQ_OUTPUT_ENABLES:  s_nxt.glb = wbyte;
        APC_IDX_CONVERTER_POWER_CONTROLS:   s_nxt.pwr = wbyte;
        APC_IDX_CONVERTER_CLOCK_REF_SELECT: s_nxt.clkref = wbyte;
        APC_IDX_CONVERTER_INPUT_REF_CTRL:   s_nxt.inref = wbyte;
        APC_IDX_CORRECTION_BYPASS_CONTROL:
          s_nxt.byp = {wbyte[7], 7'h00};
        APC_IDX_CONVERTER_IRQ_ENABLES:      s_nxt.ie = wbyte;
        APC_IDX_ROUND_ROBIN_RUN_CONTROL:    s_nxt.rr = wbyte;
        default: ;
      endcase
    end

    // Bus handshake: one wait cycle, then data and ready
    if (s_r.pend) begin
      s_nxt.pend   = 1'b0;
      s_nxt.hready = 1'b1;
      s_nxt.hrdata = (!s_r.pend_wr && s_r.pend_ok) ? {24'h000000, rbyte} : 32'h00000000;
    end else if (accept) begin
      s_nxt.pend     = 1'b1;
      s_nxt.pend_wr  = hwrite;
      s_nxt.pend_ok  = (haddr[31:13] == 19'h00000) && (haddr[1:0] == 2'b00);
      s_nxt.pend_idx = haddr[12:2];
      s_nxt.hready   = 1'b0;
    end

    // Interrupt output from enabled flags under the global enable
    s_nxt.irq = s_nxt.glb[APC_GLOBAL_CONVERTER_IRQ_ENABLE_BIT]
              & |(s_nxt.st0 & s_nxt.ie
                  & ((8'h01 << APC_DONE_BIT) | (8'h01 << APC_READY_BIT)
                     | (8'h01 << APC_CALIBRATION_BIT)));
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r        <= '0;
      s_r.hready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign hreadyout                 = s_r.hready;
  assign hresp                     = 1'b0;
  assign hrdata                    = s_r.hrdata;
  assign converter_power_on        = s_r.pwr[APC_CONVERTER_POWER_ON_BIT];
  assign input_buffer_power_on     = s_r.pwr[APC_INPUT_BUFFER_POWER_ON_BIT];
  assign reference_buffer_power_on = s_r.pwr[APC_REFERENCE_BUFFER_POWER_ON_BIT];
  assign charge_pump_power_on      = s_r.pwr[APC_CHARGE_PUMP_POWER_ON_BIT];
  assign converter_clock_enable    = s_r.clkref[APC_CLOCK_ENABLE_BIT];
  assign rail_1v8_ref_select       = s_r.clkref[APC_RAIL_1V8_REF_SELECT_BIT];
  assign external_ref_select       = s_r.inref[APC_EXTERNAL_REF_SELECT_BIT];
  assign correction_bypass         = s_r.byp[APC_CORRECTION_BYPASS_BIT];
  assign sequencer_run             = s_r.rr[APC_SEQUENCER_RUN_BIT];
  assign converter_usable          = settle.settled;
  assign converter_irq             = s_r.irq;

endmodule // apc_top

/* core/apc_pkg.sv */
// Package: register map, field positions, reset values and timing of the converter control
package apc_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [10:0] APC_IDX_GLOBAL_IRQ_OUTPUT_ENABLES  = 11'h01e;
  localparam logic [10:0] APC_IDX_CONVERTER_POWER_CONTROLS   = 11'h500;
  localparam logic [10:0] APC_IDX_CONVERTER_CLOCK_REF_SELECT = 11'h501;
  localparam logic [10:0] APC_IDX_CONVERTER_INPUT_REF_CTRL   = 11'h502;
  localparam logic [10:0] APC_IDX_RESULT_LOW                 = 11'h508;
  localparam logic [10:0] APC_IDX_CORRECTION_BYPASS_CONTROL  = 11'h509;
  localparam logic [10:0] APC_IDX_CONVERTER_IRQ_ENABLES      = 11'h50c;
  localparam logic [10:0] APC_IDX_CONVERTER_IRQ_STATUS_0     = 11'h510;
  localparam logic [10:0] APC_IDX_CONVERTER_IRQ_STATUS_1     = 11'h511;
  localparam logic [10:0] APC_IDX_CONVERTER_IRQ_STATUS_2     = 11'h512;
  localparam logic [10:0] APC_IDX_CONVERTER_IRQ_STATUS_3     = 11'h513;
  localparam logic [10:0] APC_IDX_ROUND_ROBIN_RUN_CONTROL    = 11'h534;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int APC_GLOBAL_CONVERTER_IRQ_ENABLE_BIT = 2;
  localparam int APC_CONVERTER_POWER_ON_BIT          = 1;
  localparam int APC_INPUT_BUFFER_POWER_ON_BIT       = 2;
  localparam int APC_REFERENCE_BUFFER_POWER_ON_BIT   = 3;
  localparam int APC_CHARGE_PUMP_POWER_ON_BIT        = 4;
  localparam int APC_CLOCK_ENABLE_BIT                = 3;
  localparam int APC_RAIL_1V8_REF_SELECT_BIT         = 2;
  localparam int APC_EXTERNAL_REF_SELECT_BIT         = 1;
  localparam int APC_CORRECTION_BYPASS_BIT           = 7;
  localparam int APC_DONE_BIT                        = 0;
  localparam int APC_READY_BIT                       = 1;
  localparam int APC_CALIBRATION_BIT                 = 7;
  localparam int APC_SEQUENCER_RUN_BIT               = 0;
  localparam int APC_RESULT_WIDTH                    = 10;
  localparam int APC_LIMIT_EVENTS                    = 24;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] APC_RST_BYTE   = 8'h00;
  localparam logic [9:0] APC_RST_RESULT = 10'h000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int APC_CLK_PERIOD_NS    = 20;
  localparam int APC_PUMP_SETTLE_NS   = 10000;
  localparam int APC_PUMP_SETTLE_CYC  =
    (APC_PUMP_SETTLE_NS + APC_CLK_PERIOD_NS - 1) / APC_CLK_PERIOD_NS;
  localparam int APC_SETTLE_CNT_W     = 9;
  localparam logic [APC_SETTLE_CNT_W-1:0] APC_SETTLE_LAST =
    APC_SETTLE_CNT_W'(APC_PUMP_SETTLE_CYC - 1);

endpackage

/* core/apc_settle_if.sv */
// Interface between the register core and the charge-pump settling timer
`timescale 1ns/1ns
interface apc_settle_if;
  logic pump_on;
  logic clock_on;
  logic settled;

  modport ctl (output pump_on, output clock_on, input settled);
  modport tmr (input pump_on, input clock_on, output settled);
endinterface

/* core/apc_settle_timer.sv */
// Charge-pump settling timer counting converter clock ticks after pump power-up
`timescale 1ns/1ns
module apc_settle_timer
  import apc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  apc_settle_if.tmr st
);

  typedef struct packed {
    logic [APC_SETTLE_CNT_W-1:0] cnt;
    logic                        settled;
  } apc_tmr_t;

  apc_tmr_t s_r;
  apc_tmr_t s_nxt;

  // ==========================================================================
  // Settling count
  // ==========================================================================
  always_comb begin
    s_nxt = s_r;
    if (!st.pump_on) begin
      // Pump off restarts the interval
      s_nxt.cnt     = '0;
      s_nxt.settled = 1'b0;
    end else if (st.clock_on && !s_r.settled) begin
      // Ticks only while the converter clock runs
      if (s_r.cnt == APC_SETTLE_LAST) begin
        s_nxt.settled = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign st.settled = s_r.settled;

endmodule // apc_settle_timer

/* verif/apc_chk_sva.sv */
// Checker: bus handshake, register-driven controls and pump settling of the converter control
`timescale 1ns/1ns
module apc_chk_sva
  import apc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        converter_power_on,
  input wire logic        input_buffer_power_on,
  input wire logic        reference_buffer_power_on,
  input wire logic        charge_pump_power_on,
  input wire logic        converter_clock_enable,
  input wire logic        rail_1v8_ref_select,
  input wire logic        external_ref_select,
  input wire logic        correction_bypass,
  input wire logic        sequencer_run,
  input wire logic        converter_usable
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  localparam logic [31:0] A_PWR = 32'h0000_1400;
  localparam logic [31:0] A_CLK = 32'h0000_1404;
  localparam logic [31:0] A_REF = 32'h0000_1408;
  localparam logic [31:0] A_BYP = 32'h0000_1424;
  localparam logic [31:0] A_RUN = 32'h0000_14d0;
  logic       tk;
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  assign tk = hsel && hready && htrans[1] && hwrite;
  // Pump-on cycles counted only while the converter clock runs
  always_comb begin
    cnt_nxt = cnt_r;
    if (!charge_pump_power_on) cnt_nxt = 10'h000;
    else if (converter_clock_enable && cnt_r != 10'h3ff) cnt_nxt = cnt_r + 10'h001;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_r <= 10'h000;
    else cnt_r <= cnt_nxt;
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wait_state;
    !hreadyout ##1 hreadyout;
  endsequence
  a_bus_two_cycle: assert property (hsel && hready && htrans[1] |=> s_wait_state)
    else $error("bus transfer not answered in two cycles");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_power_write: assert property (tk && haddr == A_PWR |-> ##2 {charge_pump_power_on,
      reference_buffer_power_on, input_buffer_power_on, converter_power_on} == $past(hwdata[4:1]))
    else $error("power controls do not follow written byte");
  a_power_hold: assert property ($changed({charge_pump_power_on, converter_power_on})
      |-> $past(tk && haddr == A_PWR, 2))
    else $error("power control changed without a write");
  a_clock_ref: assert property (tk && haddr == A_CLK |-> ##2
      {converter_clock_enable, rail_1v8_ref_select} == $past(hwdata[3:2]))
    else $error("clock or reference choice does not follow write");
  a_ext_ref: assert property (tk && haddr == A_REF |-> ##2 external_ref_select == $past(hwdata[1]))
    else $error("external reference select does not follow write");
  a_bypass_write: assert property (tk && haddr == A_BYP |-> ##2 correction_bypass == $past(hwdata[7]))
    else $error("correction bypass does not follow write");
  a_run_write: assert property (tk && haddr == A_RUN |-> ##2 sequencer_run == $past(hwdata[0]))
    else $error("sequencer run does not follow write");
  a_usable_drop: assert property (!charge_pump_power_on |=> !converter_usable)
    else $error("converter usable with pump off");
  a_usable_early: assert property (converter_usable |-> cnt_r >= 10'd498)
    else $error("converter usable before pump settled");
  a_usable_late: assert property (cnt_r >= 10'd503 |-> converter_usable)
    else $error("converter not usable after settling");
endmodule // apc_chk_sva

/* verif/tb_apc_top.sv */
// Testbench: register access, power-up, settling, interrupt flags and shutdown
`timescale 1ns/1ns
module tb_apc_top;
  import apc_pkg::*;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp, cde, cale, rdy_unused;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [23:0] lim;
  logic [9:0]  res;
  logic [8:0]  ctl;
  logic        p0, p1, p2, p3, ce, rs, xs, cb, sr, usable, irq;
  logic [7:0]  sh [0:2047];
  logic [7:0]  d;
  logic [10:0] rw [7] = '{11'h01e, 11'h500, 11'h501, 11'h502, 11'h509, 11'h50c, 11'h534};
  int          n_mismatch, checks_done, cyc, seed, n, k;
  assign hready = hreadyout;
  assign ctl = {p3, p2, p1, p0, ce, rs, xs, cb, sr};
  apc_top dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .conversion_done_evt(cde), .calibration_done_evt(cale),
    .limit_evt(lim), .result_in(res), .converter_power_on(p0), .input_buffer_power_on(p1),
    .reference_buffer_power_on(p2), .charge_pump_power_on(p3), .converter_clock_enable(ce),
    .rail_1v8_ref_select(rs), .external_ref_select(xs), .correction_bypass(cb),
    .sequencer_run(sr), .converter_usable(usable), .converter_irq(irq));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ==========================================================================
  // Tasks and expectations
  // ==========================================================================
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One single transfer; ready is read mid-cycle, which equals its value at the next edge
  task automatic bus(input logic w, input logic [10:0] i, input logic [7:0] dv);
    logic rdy;
    @(posedge clk);
    htrans <= 2'b10; haddr <= {19'h0, i, 2'b00}; hwrite <= w;
    rdy = 1'b0;
    while (!rdy) begin @(negedge clk); rdy = (hreadyout === 1'b1); @(posedge clk); end
    htrans <= 2'b00; hwdata <= {24'h0, dv};
    rdy = 1'b0;
    while (!rdy) begin @(negedge clk); rdy = (hreadyout === 1'b1); rd = hrdata; @(posedge clk); end
  endtask
  task automatic wr(input logic [10:0] i, input logic [7:0] dv);
    sh[i] = dv;
    bus(1'b1, i, dv);
  endtask
  task automatic rchk(input string nm, input logic [10:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(nm, rd, {24'h0, e});
  endtask
  task automatic pulse(input int b);
    if (b == 24) cde <= 1'b1; else if (b == 25) cale <= 1'b1; else lim[b] <= 1'b1;
    repeat (6) @(posedge clk);
    cde <= 1'b0; cale <= 1'b0; lim <= 24'h0;
    @(posedge clk);
  endtask
  function automatic logic [8:0] exp_ctl();
    return {sh[11'h500][4:1], sh[11'h501][3:2], sh[11'h502][1], sh[11'h509][7], sh[11'h534][0]};
  endfunction
  function automatic logic [7:0] stored(input logic [10:0] i, input logic [7:0] dv);
    return (i == 11'h509) ? {dv[7], 7'h00} : dv;
  endfunction
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed = 72636; clk = 0; rst = 1; hsel = 1; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010;
    hwdata = 0; cde = 0; cale = 0; lim = 0; res = 0; n_mismatch = 0; checks_done = 0; cyc = 0;
    sh = '{default: 8'h00};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rw[i]) rchk("reset value", rw[i], 8'h00);
    for (k = 0; k < 4; k++) rchk("status reset", 11'h510 + 11'(k), 8'h00);
    chk("outputs after reset", {ctl, usable, irq}, 32'h0);
    $display("test reset done");
    repeat (3) foreach (rw[i]) begin
      d = 8'($random(seed));
      wr(rw[i], d);
      rchk("readback", rw[i], stored(rw[i], d));
      chk("controls", ctl, exp_ctl());
    end
    wr(11'h7ff, 8'hff);
    rchk("unmapped", 11'h7ff, 8'h00);
    $display("test registers done");
    wr(11'h534, 8'h00); wr(11'h500, 8'h00); wr(11'h501, 8'h00);
    wr(11'h1e, 8'h04); wr(11'h501, 8'h08); wr(11'h502, 8'h00); wr(11'h509, 8'h00);
    wr(11'h50c, 8'h83);
    for (k = 0; k < 4; k++) bus(1'b0, 11'h510 + 11'(k), 8'h00);
    chk("irq cleared", irq, 1'b0);
    wr(11'h500, 8'h1e);
    repeat (440) @(posedge clk);
    chk("unusable while settling", usable, 1'b0);
    n = 0;
    while (usable !== 1'b1 && n < 200) begin @(posedge clk); n++; end
    chk("settle length", (n >= APC_PUMP_SETTLE_CYC - 448 && n <= APC_PUMP_SETTLE_CYC - 436), 1);
    repeat (6) @(posedge clk);
    chk("ready irq", irq, 1'b1);
    rchk("ready flag", 11'h510, 8'h02);
    chk("irq after read", irq, 1'b0);
    rchk("ready cleared", 11'h510, 8'h00);
    $display("test power-up done");
    wr(11'h1e, 8'h00);
    res <= 10'($random(seed));
    @(posedge clk);
    pulse(24);
    chk("irq gated", irq, 1'b0);
    rchk("result low", 11'h508, res[7:0]);
    rchk("result high", 11'h509, {6'h00, res[9:8]});
    rchk("done flag", 11'h510, 8'h01);
    wr(11'h1e, 8'h04);
    pulse(25);
    chk("cal irq", irq, 1'b1);
    rchk("cal flag", 11'h510, 8'h80);
    chk("cal irq cleared", irq, 1'b0);
    wr(11'h50c, 8'h00);
    pulse(24);
    chk("irq masked", irq, 1'b0);
    rchk("masked flag", 11'h510, 8'h01);
    $display("test interrupts done");
    repeat (6) begin
      k = {$random(seed)} % 24;
      pulse(k);
      rchk("limit flag", 11'h511 + 11'(k / 8), 8'h01 << (k % 8));
      rchk("limit cleared", 11'h511 + 11'(k / 8), 8'h00);
    end
    $display("test limits done");
    wr(11'h534, 8'h00); wr(11'h500, 8'h00);
    // Timer drops usable on the edge the write returns at
    @(posedge clk);
    chk("usable after pump off", usable, 1'b0);
    wr(11'h501, 8'h00);
    chk("controls after shutdown", ctl, exp_ctl());
    $display("test shutdown done");
    end_sim();
  end
endmodule // tb_apc_top
bind apc_top apc_chk_sva u_chk (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .converter_power_on(converter_power_on),
  .input_buffer_power_on(input_buffer_power_on),
  .reference_buffer_power_on(reference_buffer_power_on),
  .charge_pump_power_on(charge_pump_power_on), .converter_clock_enable(converter_clock_enable),
  .rail_1v8_ref_select(rail_1v8_ref_select), .external_ref_select(external_ref_select),
  .correction_bypass(correction_bypass), .sequencer_run(sequencer_run),
  .converter_usable(converter_usable));
